// >>> shared/bcs_map.vh
// Purpose: Constants for the bus command and shared chip-select block.
// Assumes: A 40 MHz system clock with a 25 ns period.
// Notes:   Status codes are the raw levels of the three active-low status pins.
`ifndef BCS_MAP_VH
`define BCS_MAP_VH

// Clock period in nanoseconds.
`define BCS_CLK_NS      25
// Least width of the address latch strobe in nanoseconds.
`define BCS_ALE_NS      50
// Strobe width in cycles, rounded up, never below one.
`define BCS_ALE_CYC     ((`BCS_ALE_NS + `BCS_CLK_NS - 1) / `BCS_CLK_NS)

// Cycle status codes.
`define BCS_ST_INTA     3'h0
`define BCS_ST_IORD     3'h1
`define BCS_ST_IOWR     3'h2
`define BCS_ST_HALT     3'h3
`define BCS_ST_FETCH    3'h4
`define BCS_ST_MRD      3'h5
`define BCS_ST_MWR      3'h6
`define BCS_ST_PASSIVE  3'h7

// Bit positions inside the synchronised input vector.
`define BCS_IN_ST_LSB   0
`define BCS_IN_ST_MSB   2
`define BCS_IN_LCS      3
`define BCS_IN_RQA      4
`define BCS_IN_RQB      5
`define BCS_IN_BUS_TAKEOVER_ACK     6
`define BCS_IN_THIRD_MASTER_TAKEOVER_ACK  7
`define BCS_IN_TREQ     8
`define BCS_IN_W        9

// Cycles during which a line we drove may still echo back through the synchroniser.
`define BCS_ECHO_CYC    3

`endif

// >>> src/bcs_sync2.v
// Purpose: Two-flop synchroniser for a vector of unrelated pin levels.
// Assumes: Each bit is an independent level; no bus coherence is implied.
// Notes:   The first stage is read by the second stage only.
`timescale 1ns/1ps

module bcs_sync2 #(
	parameter W         = 1,
	parameter RESET_VAL = 1
) (
	input  wire         clk_i,
	input  wire         srst_i,
	input  wire [W-1:0] d_i,
	output wire [W-1:0] q_o
);

	// One two-stage chain per bit, so each bit can settle on its own.
	genvar g;
	generate
		for (g = 0; g < W; g = g + 1) begin : g_bit
			reg meta_q;   // First stage, may go metastable.
			reg stab_q;   // Second stage, safe for logic.
			// Reset loads the idle pin level so no false edge is seen on release.
			always @(posedge clk_i) begin
				if (srst_i) begin
					meta_q <= RESET_VAL[g];
					stab_q <= RESET_VAL[g];
				end else begin
					meta_q <= d_i[g];
					stab_q <= meta_q;
				end
			end
			assign q_o[g] = stab_q;
		end
	endgenerate

endmodule // bcs_sync2

// >>> src/bcs_top.v
// Purpose: Bus command generator and shared chip-select path between a host and a coprocessor.
// Assumes: All pin inputs are asynchronous to clk_i; request/grant lines are active-low open drain.
// Notes:   One clk_i cycle stands for one host clock phase.
`timescale 1ns/1ps
`include "bcs_map.vh"

module bcs_top #(
	parameter ALE_CYC = `BCS_ALE_CYC,
	parameter ECHO    = `BCS_ECHO_CYC
) (
	input  wire       clk_i,
	input  wire       srst_i,
	input  wire [2:0] cycle_status_lines_i,
	input  wire       lower_region_select_n_i,
	input  wire       coproc_req_grant_a_i,
	output wire       coproc_req_grant_a_o,
	output wire       coproc_req_grant_a_oe_o,
	input  wire       coproc_req_grant_b_i,
	output wire       coproc_req_grant_b_o,
	output wire       coproc_req_grant_b_oe_o,
	output wire       bus_takeover_req_o,
	input  wire       bus_takeover_ack_i,
	input  wire       third_master_req_i,
	output wire       third_master_grant_o,
	input  wire       third_master_takeover_ack_i,
	output wire       addr_latch_o,
	output wire       rd_n_o,
	output wire       wr_n_o,
	output wire       data_buffer_enable_n_o,
	output wire       transfer_direction_o,
	output wire       select_out_n_o
);

	// Command sequencer states.
	localparam [1:0] C_IDLE = 2'h0;
	localparam [1:0] C_ALE  = 2'h1;
	localparam [1:0] C_CMD  = 2'h2;

	// Line a arbitration states.
	localparam [1:0] A_IDLE  = 2'h0;
	localparam [1:0] A_HOLD  = 2'h1;
	localparam [1:0] A_GRANT = 2'h2;
	localparam [1:0] A_OWN   = 2'h3;

	// Line b arbitration states.
	localparam [2:0] B_IDLE  = 3'h0;
	localparam [2:0] B_REQ   = 3'h1;
	localparam [2:0] B_WAIT  = 3'h2;
	localparam [2:0] B_THIRD = 3'h3;
	localparam [2:0] B_REL   = 3'h4;

	// Returns high for status codes that read data into the host side.
	function is_read;
		input [2:0] st;
		begin
			is_read = (st == `BCS_ST_INTA) || (st == `BCS_ST_IORD) ||
			          (st == `BCS_ST_FETCH) || (st == `BCS_ST_MRD);
		end
	endfunction

	// Returns high for status codes that write data out.
	function is_write;
		input [2:0] st;
		begin
			is_write = (st == `BCS_ST_IOWR) || (st == `BCS_ST_MWR);
		end
	endfunction

	wire [`BCS_IN_W-1:0] raw_in;     // Pin levels before synchronising.
	wire [`BCS_IN_W-1:0] sync_in;    // Pin levels after two flops.
	wire [2:0]           st_s;       // Synchronised cycle status.
	wire                 lcs_n_s;    // Synchronised select input.
	wire                 rqa_s;      // Synchronised line a.
	wire                 rqb_s;      // Synchronised line b.
	wire                 bus_takeover_ack_s;     // Synchronised host takeover ack.
	wire                 sysack_s;   // Synchronised third master ack.
	wire                 treq_s;     // Synchronised third master request.

	assign raw_in = {third_master_req_i, third_master_takeover_ack_i, bus_takeover_ack_i,
	                 coproc_req_grant_b_i, coproc_req_grant_a_i, lower_region_select_n_i,
	                 cycle_status_lines_i};

	// Every pin crosses two flops before any logic looks at it.
	bcs_sync2 #(
		.W         (`BCS_IN_W),
		.RESET_VAL ({3'h0, 6'h3F})
	) u_sync (
		.clk_i  (clk_i),
		.srst_i (srst_i),
		.d_i    (raw_in),
		.q_o    (sync_in)
	);

	assign st_s     = sync_in[`BCS_IN_ST_MSB:`BCS_IN_ST_LSB];
	assign lcs_n_s  = sync_in[`BCS_IN_LCS];
	assign rqa_s    = sync_in[`BCS_IN_RQA];
	assign rqb_s    = sync_in[`BCS_IN_RQB];
	assign bus_takeover_ack_s   = sync_in[`BCS_IN_BUS_TAKEOVER_ACK];
	assign sysack_s = sync_in[`BCS_IN_THIRD_MASTER_TAKEOVER_ACK];
	assign treq_s   = sync_in[`BCS_IN_TREQ];

	reg [1:0] a_st_q;            // Line a arbitration state.
	reg       a_oe_q;            // Driving line a low.
	reg       hold_q;            // Takeover request to the host.
	reg [2:0] b_st_q;            // Line b arbitration state.
	reg       b_oe_q;            // Driving line b low.
	reg       tgrant_q;          // Grant to the third master.
	reg       owns_q;            // Coprocessor owns the bus.
	reg       sel_n_q;           // Select output, active low.
	reg [2:0]  st_prev_q;        // Status one cycle back, for the start edge.
	reg        rqa_prev_q;       // Line a one cycle back.
	reg        rqb_prev_q;       // Line b one cycle back.
	reg        sysack_prev_q;    // Third master ack one cycle back.
	reg        treq_prev_q;      // Third master request one cycle back.
	reg [ECHO-1:0] a_echo_q;     // Recent own drives of line a.
	reg [ECHO-1:0] b_echo_q;     // Recent own drives of line b.

	// Edge history registers; edges are taken from the stable stage only.
	always @(posedge clk_i) begin
		if (srst_i) begin
			st_prev_q     <= `BCS_ST_PASSIVE;
			rqa_prev_q    <= 1'b1;
			rqb_prev_q    <= 1'b1;
			sysack_prev_q <= 1'b0;
			treq_prev_q   <= 1'b0;
			a_echo_q      <= {ECHO{1'b0}};
			b_echo_q      <= {ECHO{1'b0}};
		end else begin
			st_prev_q     <= st_s;
			rqa_prev_q    <= rqa_s;
			rqb_prev_q    <= rqb_s;
			sysack_prev_q <= sysack_s;
			treq_prev_q   <= treq_s;
			a_echo_q      <= {a_echo_q[ECHO-2:0], a_oe_q};
			b_echo_q      <= {b_echo_q[ECHO-2:0], b_oe_q};
		end
	end

	// A pulse from the far side is a falling edge not caused by our own drive.
	// The echo mask costs a few cycles of blindness after each drive, which the
	// protocol tolerates because the far side never answers that quickly.
	wire a_pulse   = rqa_prev_q & ~rqa_s & ~(|a_echo_q) & ~a_oe_q;
	wire b_pulse   = rqb_prev_q & ~rqb_s & ~(|b_echo_q) & ~b_oe_q;
	wire cyc_start = (st_prev_q == `BCS_ST_PASSIVE) && (st_s != `BCS_ST_PASSIVE);

	reg [1:0] cmd_q;             // Command sequencer state.
	reg [2:0] cyc_st_q;          // Status latched at the cycle start.
	reg [7:0] ale_cnt_q;         // Remaining latch strobe cycles.
	reg       ale_q;             // Address latch strobe.
	reg       rd_n_q;            // Read strobe, active low.
	reg       wr_n_q;            // Write strobe, active low.
	reg       den_n_q;           // Data buffer enable, active low.
	reg       dir_q;             // Transfer direction, high means transmit.

	// Command sequencer: latch, then strobe until the status goes passive.
	always @(posedge clk_i) begin
		if (srst_i) begin
			cmd_q     <= C_IDLE;
			cyc_st_q  <= `BCS_ST_PASSIVE;
			ale_cnt_q <= 8'h00;
			ale_q     <= 1'b0;
			rd_n_q    <= 1'b1;
			wr_n_q    <= 1'b1;
			den_n_q   <= 1'b1;
			dir_q     <= 1'b1;
		end else begin
			case (cmd_q)
				C_IDLE: begin
					rd_n_q  <= 1'b1;
					wr_n_q  <= 1'b1;
					den_n_q <= 1'b1;
					// Status is already stable here, so the strobe starts late by design.
					if (cyc_start) begin
						cyc_st_q  <= st_s;
						ale_q     <= 1'b1;
						ale_cnt_q <= ALE_CYC[7:0];
						cmd_q     <= C_ALE;
						// Direction only moves here; a halt keeps the old level.
						if (is_read(st_s)) begin
							dir_q <= 1'b0;
						end else if (is_write(st_s)) begin
							dir_q <= 1'b1;
						end
					end
				end
				C_ALE: begin
					// Fixed width ends the strobe at the same point every cycle.
					if (ale_cnt_q <= 8'h01) begin
						ale_q <= 1'b0;
						cmd_q <= C_CMD;
						if (st_s != `BCS_ST_PASSIVE) begin
							rd_n_q  <= ~is_read(cyc_st_q);
							wr_n_q  <= ~is_write(cyc_st_q);
							den_n_q <= ~(is_read(cyc_st_q) | is_write(cyc_st_q));
						end
					end else begin
						ale_cnt_q <= ale_cnt_q - 8'h01;
					end
				end
				C_CMD: begin
					// Strobes end as soon as the host signals the cycle is over.
					if (st_s == `BCS_ST_PASSIVE) begin
						rd_n_q  <= 1'b1;
						wr_n_q  <= 1'b1;
						den_n_q <= 1'b1;
						cmd_q   <= C_IDLE;
					end
				end
				default: begin
					cmd_q <= C_IDLE;
				end
			endcase
		end
	end

	// Line a: coprocessor request, host takeover, grant, then release.
	always @(posedge clk_i) begin
		if (srst_i) begin
			a_st_q <= A_IDLE;
			a_oe_q <= 1'b0;
			hold_q <= 1'b0;
		end else begin
			a_oe_q <= 1'b0;
			case (a_st_q)
				A_IDLE: begin
					if (a_pulse) begin
						hold_q <= 1'b1;
						a_st_q <= A_HOLD;
					end
				end
				A_HOLD: begin
					// The grant waits for the host to give up the bus.
					if (bus_takeover_ack_s) begin
						a_oe_q <= 1'b1;
						a_st_q <= A_GRANT;
					end
				end
				A_GRANT: begin
					a_st_q <= A_OWN;
				end
				A_OWN: begin
					if (a_pulse) begin
						hold_q <= 1'b0;
						a_st_q <= A_IDLE;
					end
				end
				default: begin
					a_st_q <= A_IDLE;
				end
			endcase
		end
	end

	// Line b: a third master takes the bus from the coprocessor and gives it back.
	always @(posedge clk_i) begin
		if (srst_i) begin
			b_st_q   <= B_IDLE;
			b_oe_q   <= 1'b0;
			tgrant_q <= 1'b0;
		end else begin
			b_oe_q <= 1'b0;
			case (b_st_q)
				B_IDLE: begin
					if (treq_s && !treq_prev_q && owns_q) begin
						b_oe_q <= 1'b1;
						b_st_q <= B_REQ;
					end
				end
				B_REQ: begin
					b_st_q <= B_WAIT;
				end
				B_WAIT: begin
					if (b_pulse) begin
						tgrant_q <= 1'b1;
						b_st_q   <= B_THIRD;
					end
				end
				B_THIRD: begin
					// The bus comes back only when the third master drops its ack.
					if (sysack_prev_q && !sysack_s) begin
						tgrant_q <= 1'b0;
						b_oe_q   <= 1'b1;
						b_st_q   <= B_REL;
					end
				end
				B_REL: begin
					b_st_q <= B_IDLE;
				end
				default: begin
					b_st_q <= B_IDLE;
				end
			endcase
		end
	end

	// Ownership flag: a set on the same edge as a clear wins.
	wire own_set = (a_st_q == A_HOLD && bus_takeover_ack_s) ||
	               (b_st_q == B_THIRD && sysack_prev_q && !sysack_s);
	wire own_clr = (a_st_q == A_OWN && a_pulse) ||
	               (b_st_q == B_WAIT && b_pulse);

	// Select path: plain buffer for the host, forced during coprocessor tenure.
	// No address is looked at, so coprocessor data must sit in the selected range.
	always @(posedge clk_i) begin
		if (srst_i) begin
			owns_q  <= 1'b0;
			sel_n_q <= 1'b1;
		end else begin
			if (own_set) begin
				owns_q <= 1'b1;
			end else if (own_clr) begin
				owns_q <= 1'b0;
			end
			sel_n_q <= lcs_n_s & ~owns_q;
		end
	end

	assign coproc_req_grant_a_o    = 1'b0;
	assign coproc_req_grant_a_oe_o = a_oe_q;
	assign coproc_req_grant_b_o    = 1'b0;
	assign coproc_req_grant_b_oe_o = b_oe_q;
	assign bus_takeover_req_o      = hold_q;
	assign third_master_grant_o    = tgrant_q;
	assign addr_latch_o            = ale_q;
	assign rd_n_o                  = rd_n_q;
	assign wr_n_o                  = wr_n_q;
	assign data_buffer_enable_n_o  = den_n_q;
	assign transfer_direction_o    = dir_q;
	assign select_out_n_o          = sel_n_q;

endmodule // bcs_top

// >>> tb/bcs_top_asserts.sv
// Purpose: Concurrent checks on the ports of the bus command and shared select block.
// Assumes: One clock; an input set at an edge is seen by the logic two edges later.
// Notes:   Bound to every instance of the top module.
`timescale 1ns/1ps
module bcs_top_asserts (
	input wire logic       clk_i,
	input wire logic       srst_i,
	input wire logic [2:0] cycle_status_lines_i,
	input wire logic       lower_region_select_n_i,
	input wire logic       bus_takeover_req_o,
	input wire logic       bus_takeover_ack_i,
	input wire logic       coproc_req_grant_a_oe_o,
	input wire logic       coproc_req_grant_b_oe_o,
	input wire logic       third_master_grant_o,
	input wire logic       addr_latch_o,
	input wire logic       rd_n_o,
	input wire logic       wr_n_o,
	input wire logic       data_buffer_enable_n_o,
	input wire logic       transfer_direction_o,
	input wire logic       select_out_n_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);
	// A cycle starts only on a passive to active change, so the strobe trails valid status.
	AST_ALE_AFTER_STATUS: assert property ($rose(addr_latch_o) |->
		$past(cycle_status_lines_i, 3) != 3'h7 && $past(cycle_status_lines_i, 4) == 3'h7)
		else $error("Latch strobe rose without a passive to active change.");
	AST_ALE_WIDTH: assert property ($rose(addr_latch_o) |=> addr_latch_o ##1 !addr_latch_o)
		else $error("Latch strobe width wrong.");
	AST_DEN_WITH_CMD: assert property ((!rd_n_o || !wr_n_o) |-> !data_buffer_enable_n_o && (rd_n_o || wr_n_o))
		else $error("Buffer enable or command strobes inconsistent.");
	AST_IDLE_WHEN_PASSIVE: assert property ((cycle_status_lines_i == 3'h7) [*4] |->
		rd_n_o && wr_n_o && data_buffer_enable_n_o)
		else $error("Strobe active while status passive.");
	AST_DIR_AT_START: assert property ($changed(transfer_direction_o) |-> $rose(addr_latch_o))
		else $error("Direction changed outside a cycle start.");
	AST_DIR_FOR_KIND: assert property ($rose(addr_latch_o) &&
		$past(cycle_status_lines_i, 3) inside {3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6} |->
		transfer_direction_o == $past(cycle_status_lines_i[1], 3))
		else $error("Direction does not suit the cycle kind.");
	// The guard on reset covers the flush of the synchroniser after a release.
	AST_SELECT_BUFFER: assert property (!$past(srst_i, 3) && !$past(srst_i, 2) && !$past(srst_i) &&
		!$past(lower_region_select_n_i, 3) |-> !select_out_n_o)
		else $error("Select out missed the select input.");
	AST_GRANT_AFTER_ACK: assert property ($rose(coproc_req_grant_a_oe_o) |->
		bus_takeover_req_o && $past(bus_takeover_ack_i) ##1 !coproc_req_grant_a_oe_o ##1 !select_out_n_o)
		else $error("Grant on line a out of order.");
	AST_B_RELEASE_ON_DROP: assert property ($fell(third_master_grant_o) |-> ##[0:1] coproc_req_grant_b_oe_o)
		else $error("No release on line b after third master left.");
endmodule // bcs_top_asserts

bind bcs_top bcs_top_asserts i_chk (.clk_i(clk_i), .srst_i(srst_i), .cycle_status_lines_i(cycle_status_lines_i),
	.lower_region_select_n_i(lower_region_select_n_i), .bus_takeover_req_o(bus_takeover_req_o),
	.bus_takeover_ack_i(bus_takeover_ack_i), .coproc_req_grant_a_oe_o(coproc_req_grant_a_oe_o),
	.coproc_req_grant_b_oe_o(coproc_req_grant_b_oe_o), .third_master_grant_o(third_master_grant_o),
	.addr_latch_o(addr_latch_o), .rd_n_o(rd_n_o), .wr_n_o(wr_n_o), .data_buffer_enable_n_o(data_buffer_enable_n_o),
	.transfer_direction_o(transfer_direction_o), .select_out_n_o(select_out_n_o));

// >>> tb/bcs_far_model.sv
// Purpose: Far side: host hold answer, coprocessor and third master on the request/grant lines.
// Assumes: Both request/grant lines have pull-ups; the bench commands coprocessor pulses on line a.
// Notes: Coprocessor operands sit inside the shared select range, so no address is modelled.
`timescale 1ns/1ps
module bcs_far_model (
	input  wire logic clk_i,
	input  wire logic srst_i,
	input  wire logic cop_pulse_i,
	input  wire logic tm_req_i,
	input  wire logic a_oe_i,
	input  wire logic b_oe_i,
	input  wire logic hold_req_i,
	input  wire logic tm_grant_i,
	output wire logic a_wire_o,
	output wire logic b_wire_o,
	output wire logic hold_ack_o,
	output wire logic tm_ack_o
);
	logic       hold_q   = 1'b0; // Host hold answer.
	logic       tm_q     = 1'b0; // Third master holds the bus.
	logic       b_held_q = 1'b0; // Coprocessor was asked for the bus on line b.
	logic [2:0] b_cnt_q  = 3'h0; // Countdown to the coprocessor grant on line b.
	// Pull-ups: a released line reads high, never the last driven level.
	assign a_wire_o   = !(a_oe_i || cop_pulse_i);
	assign b_wire_o   = !(b_oe_i || (b_cnt_q == 3'h1));
	assign hold_ack_o = hold_q;
	assign tm_ack_o   = tm_q;
	// The grant on line b comes well after the block's echo window, as a slow coprocessor would.
	always @(posedge clk_i) begin
		if (srst_i) begin
			hold_q   <= 1'b0;
			tm_q     <= 1'b0;
			b_held_q <= 1'b0;
			b_cnt_q  <= 3'h0;
		end else begin
			hold_q <= hold_req_i;
			tm_q   <= tm_grant_i && tm_req_i;
			if (b_oe_i && !b_held_q) begin
				b_held_q <= 1'b1;
				b_cnt_q  <= 3'h5;
			end else begin
				if (b_oe_i)
					b_held_q <= 1'b0;
				if (b_cnt_q != 3'h0)
					b_cnt_q <= b_cnt_q - 3'h1;
			end
		end
	end
endmodule // bcs_far_model

// >>> tb/bus_command_and_chip_select_tb.sv
// Purpose: Self-checking bench for the bus command and shared select block.
// Assumes: A 25 ns clock; inputs change by non-blocking assignment at rising edges.
// Notes:   Each scenario task drives the block and judges its answers before returning.
`timescale 1ns/1ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin err_count++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, got, exp); end end
module bus_command_and_chip_select_tb;
	logic       clk_i = 1'b0;
	logic       srst_i = 1'b1;
	logic [2:0] st = 3'h7;
	logic       lsel_n = 1'b1;
	logic       cop_pulse = 1'b0;
	logic       tm_req = 1'b0;
	wire        a_i, b_i, ack, tm_ack, a_oe, b_oe, hold, tm_grant;
	wire        ale, rd_n, wr_n, den_n, dir, sel_n, a_dat, b_dat;
	int         err_count = 0;
	int         checks = 0;
	always #12.5 clk_i = ~clk_i;
	bcs_top i_dut (.clk_i(clk_i), .srst_i(srst_i), .cycle_status_lines_i(st), .lower_region_select_n_i(lsel_n),
		.coproc_req_grant_a_i(a_i), .coproc_req_grant_a_o(a_dat), .coproc_req_grant_a_oe_o(a_oe),
		.coproc_req_grant_b_i(b_i), .coproc_req_grant_b_o(b_dat), .coproc_req_grant_b_oe_o(b_oe),
		.bus_takeover_req_o(hold), .bus_takeover_ack_i(ack), .third_master_req_i(tm_req),
		.third_master_grant_o(tm_grant), .third_master_takeover_ack_i(tm_ack), .addr_latch_o(ale),
		.rd_n_o(rd_n), .wr_n_o(wr_n), .data_buffer_enable_n_o(den_n), .transfer_direction_o(dir),
		.select_out_n_o(sel_n));
	bcs_far_model i_far (.clk_i(clk_i), .srst_i(srst_i), .cop_pulse_i(cop_pulse), .tm_req_i(tm_req),
		.a_oe_i(a_oe), .b_oe_i(b_oe), .hold_req_i(hold), .tm_grant_i(tm_grant), .a_wire_o(a_i),
		.b_wire_o(b_i), .hold_ack_o(ack), .tm_ack_o(tm_ack));
	// Sample just after an edge so that the edge's updates have landed.
	task automatic step(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task automatic wrap_up;
		$display("Comparisons %0d, mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// One full bus cycle of the given kind, then passive.
	task automatic run_cycle(input logic [2:0] code, input logic exp_dir);
		logic rd_e;
		logic wr_e;
		rd_e = !(code inside {3'h0, 3'h1, 3'h4, 3'h5});
		wr_e = !(code inside {3'h2, 3'h6});
		@(posedge clk_i) st <= code;
		step(3);
		`CHK(ale, 1'b1)
		`CHK(dir, exp_dir)
		step(1);
		`CHK(ale, 1'b1)
		step(1);
		`CHK({ale, rd_n, wr_n, den_n}, {1'b0, rd_e, wr_e, rd_e & wr_e})
		@(posedge clk_i) st <= 3'h7;
		step(3);
		`CHK({rd_n, wr_n, den_n, dir}, {3'h7, exp_dir})
	endtask
	// Every kind, back to back, including repeats that must not move the direction.
	task automatic t_commands;
		logic [2:0] codes [9] = '{3'h5, 3'h5, 3'h6, 3'h6, 3'h1, 3'h3, 3'h2, 3'h0, 3'h4};
		logic       e;
		e = 1'b1;
		foreach (codes[k]) begin
			if (codes[k] != 3'h3)
				e = codes[k][1];
			run_cycle(codes[k], e);
		end
	endtask
	// Status falls back to passive while the latch strobe runs: no command follows.
	task automatic t_abort;
		@(posedge clk_i) st <= 3'h5;
		@(posedge clk_i) st <= 3'h7;
		step(4);
		`CHK({ale, rd_n, den_n}, 3'h3)
		step(3);
	endtask
	// Host select, coprocessor tenure, third master hand-off and release.
	task automatic t_select;
		int i;
		@(posedge clk_i) lsel_n <= 1'b0;
		step(3);
		`CHK(sel_n, 1'b0)
		@(posedge clk_i) lsel_n <= 1'b1;
		step(3);
		`CHK(sel_n, 1'b1)
		@(posedge clk_i) cop_pulse <= 1'b1;
		@(posedge clk_i) cop_pulse <= 1'b0;
		for (i = 0; i < 30 && a_oe !== 1'b1; i++) step(1);
		`CHK({a_oe, hold}, 2'h3)
		step(1);
		`CHK(sel_n, 1'b0)
		step(10);
		`CHK(sel_n, 1'b0)
		@(posedge clk_i) tm_req <= 1'b1;
		for (i = 0; i < 40 && tm_grant !== 1'b1; i++) step(1);
		`CHK(tm_grant, 1'b1)
		step(1);
		`CHK(sel_n, 1'b1)
		@(posedge clk_i) tm_req <= 1'b0;
		for (i = 0; i < 30 && b_oe !== 1'b1; i++) step(1);
		`CHK(b_oe, 1'b1)
		step(1);
		`CHK({sel_n, tm_grant}, 2'h0)
		@(posedge clk_i) cop_pulse <= 1'b1;
		@(posedge clk_i) cop_pulse <= 1'b0;
		for (i = 0; i < 30 && hold !== 1'b0; i++) step(1);
		`CHK(hold, 1'b0)
		step(1);
		`CHK(sel_n, 1'b1)
	endtask
	initial begin
		repeat (8) @(posedge clk_i);
		srst_i <= 1'b0;
		t_commands;
		t_abort;
		t_select;
		@(posedge clk_i) srst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		srst_i <= 1'b0;
		step(2);
		// Reset must return the direction to transmit and leave every strobe and grant idle.
		`CHK({ale, rd_n, wr_n, den_n, dir, sel_n, a_oe, b_oe, hold, tm_grant, a_dat, b_dat}, 12'h7C0)
		run_cycle(3'h6, 1'b1);
		wrap_up;
	end
	// Cut a hang short well past the expected run of under a thousand cycles.
	initial begin
		#(25 * 4000);
		err_count++;
		wrap_up;
	end
endmodule // bus_command_and_chip_select_tb
